// >>> src/ocl_channel_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ocl_channel_ctrl
  import ocl_pkg::*;
#(
  parameter int unsigned CAL_CYCLES_P = CAL_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWe,
  input  wire logic        regRe,
  output logic      [7:0]  regRdata,
  output logic             hostWait,
  output logic             powerReady,
  input  wire logic        supplyOk,
  input  wire logic        hostMode,
  input  wire logic        remoteLoopback0,
  input  wire logic        timingRecoveryPin,
  input  wire logic        cableImpedanceSelect,
  input  wire logic [2:0]  cableReachCode,
  input  wire logic [3:0]  monitorSelectPins,
  input  wire logic [7:0]  transmitClockIn,
  input  wire logic [7:0]  txPositiveData,
  input  wire logic [7:0]  txNegativeData,
  input  wire logic [7:0]  lossOfSignal,
  input  wire logic [7:0]  allOnesAlarm,
  input  wire logic [7:0]  lineRxPositive,
  input  wire logic [7:0]  lineRxNegative,
  input  wire logic [7:0]  lineRxClock,
  output logic      [7:0]  lineOutA,
  output logic      [7:0]  lineOutB,
  output logic      [7:0]  rxPositiveData,
  output logic      [7:0]  rxNegativeData,
  output logic      [7:0]  rxClockOut,
  output logic      [31:0] lineReach,
  output logic      [7:0]  lineImp75,
  output logic      [7:0]  timingRecovery
);

  localparam int unsigned SYNC_W = 76;
  localparam logic [19:0] CAL_LAST = 20'(CAL_CYCLES_P - 1);
  localparam logic [3:0]  DIV_LAST = 4'(REF_DIV - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] syncIn;
  logic [SYNC_W-1:0] syncOut;
  logic              supplyS;
  logic              hostModeS;
  logic              rlS;
  logic              trPinS;
  logic              cblS;
  logic [2:0]        reachS;
  logic [3:0]        strapMonS;
  logic [7:0]        tclkS;
  logic [7:0]        tposS;
  logic [7:0]        tnegS;
  logic [7:0]        losS;
  logic [7:0]        allOnesS;
  logic [7:0]        rxPosS;
  logic [7:0]        rxNegS;
  logic [7:0]        rxClkS;

  assign syncIn = {supplyOk, hostMode, remoteLoopback0, timingRecoveryPin,
                   cableImpedanceSelect, cableReachCode, monitorSelectPins,
                   transmitClockIn, txPositiveData, txNegativeData,
                   lossOfSignal, allOnesAlarm, lineRxPositive,
                   lineRxNegative, lineRxClock};

  ocl_sync3 #(.W(SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (syncIn),
    .dout    (syncOut)
  );

  assign {supplyS, hostModeS, rlS, trPinS, cblS, reachS, strapMonS,
          tclkS, tposS, tnegS, losS, allOnesS, rxPosS, rxNegS,
          rxClkS} = syncOut;

  // ---------------------------------------------------------------
  // power-up and calibration
  // ---------------------------------------------------------------
  ocl_pwr_e    pwrQ;
  logic [19:0] calCntQ;
  logic        readyQ;
  logic        cfgClr;

  // held static until the supply detector trips, then a timed calibration
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pwrQ    <= PWR_STATIC;
      calCntQ <= 20'h0_0000;
      readyQ  <= 1'b0;
    end else begin
      unique case (pwrQ)
        PWR_STATIC: begin
          calCntQ <= 20'h0_0000;
          if (supplyS) begin
            pwrQ <= PWR_CAL;
          end
        end
        PWR_CAL: begin
          if (calCntQ == CAL_LAST) begin  // [RQ1]
            pwrQ   <= PWR_RUN;
            readyQ <= 1'b1;
          end else begin
            calCntQ <= calCntQ + 20'h0_0001;
          end
        end
        PWR_RUN: begin
          if (!supplyS) begin
            pwrQ   <= PWR_STATIC;
            readyQ <= 1'b0;
          end
        end
      endcase
    end
  end

  // registers and channel state sit at defaults until calibrated
  assign cfgClr = srst | ~readyQ;  // [RQ1]

  // ---------------------------------------------------------------
  // reference timing enable
  // ---------------------------------------------------------------
  logic [3:0] divCntQ;
  logic       refTickQ;
  logic       refLvlQ;

  // reference rate is a tick from a divider; jitter on ref_clk passes through
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divCntQ  <= 4'h0;
      refTickQ <= 1'b0;
      refLvlQ  <= 1'b0;
    end else begin
      refTickQ <= (divCntQ == DIV_LAST);  // [RQ2]
      if (divCntQ == DIV_LAST) begin
        divCntQ <= 4'h0;
        refLvlQ <= ~refLvlQ;
      end else begin
        divCntQ <= divCntQ + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] monSelQ;
  logic [7:0] llIndexQ;
  logic [7:0] trEnQ;
  logic [3:0] reachQ [NCH];
  logic [7:0] regRdataQ;
  logic       hostWaitQ;
  logic       wrOk;
  logic [7:0] statusW;

  assign wrOk = regWe & readyQ;

  // software writes; writes during calibration are dropped
  always_ff @(posedge ref_clk) begin
    if (cfgClr) begin
      monSelQ  <= RST_MON_SEL;
      llIndexQ <= RST_LL_INDEX;
      trEnQ    <= RST_TR_ENABLE;
      for (int c = 0; c < NCH; c++) begin
        reachQ[c] <= RST_REACH;
      end
    end else if (wrOk) begin
      unique case (regAddr)
        OFS_MON_SEL:   monSelQ  <= regWdata;  // [RQ9]
        OFS_LL_INDEX:  llIndexQ <= regWdata;  // [RQ17]
        OFS_LL_VALUE:  reachQ[llIndexQ[2:0]] <= regWdata[3:0];  // [RQ17] [RQ19]
        OFS_TR_ENABLE: trEnQ    <= regWdata;  // [RQ13]
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      regRdataQ <= 8'h00;
    end else if (regRe) begin
      unique case (regAddr)
        OFS_MON_SEL:   regRdataQ <= monSelQ;
        OFS_LL_INDEX:  regRdataQ <= llIndexQ;
        OFS_LL_VALUE:  regRdataQ <= {4'h0, reachQ[llIndexQ[2:0]]};
        OFS_TR_ENABLE: regRdataQ <= trEnQ;
        OFS_STATUS:    regRdataQ <= statusW;
        default:       regRdataQ <= 8'h00;
      endcase
    end else begin
      regRdataQ <= 8'h00;
    end
  end

  // wait indication paced by the reference; a new access wins over the clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hostWaitQ <= 1'b0;
    end else if (regWe || regRe) begin
      hostWaitQ <= 1'b1;
    end else if (refTickQ) begin
      hostWaitQ <= 1'b0;  // [RQ5]
    end
  end

  // ---------------------------------------------------------------
  // monitor multiplexer
  // ---------------------------------------------------------------
  logic [3:0] monCode;
  logic       monOn;
  logic       monTx;
  logic [2:0] monCh;
  logic       monPos;
  logic       monNeg;
  logic       monClk;
  logic [7:0] tclkPrevQ;
  logic [7:0] tclkFall;
  logic [7:0] txAW;
  logic [7:0] txBW;

  // pin code and register share one decode; x000 means off
  assign monCode = hostModeS ? monSelQ[3:0] : strapMonS;  // [RQ9] [RQ10]
  assign monCh   = monCode[2:0];
  assign monOn   = |monCh;  // [RQ10] [RQ21]
  assign monTx   = monCode[MON_TX_BIT];
  assign monPos  = monTx ? txAW[monCh] : rxPosS[monCh];  // [RQ7]
  assign monNeg  = monTx ? txBW[monCh] : rxNegS[monCh];  // [RQ7]
  assign monClk  = monTx ? tclkS[monCh] : rxClkS[monCh];
  assign statusW = {5'h00, monOn, hostModeS, readyQ};

  // transmit clock edges found on the synchronised level
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tclkPrevQ <= 8'h00;
    end else begin
      tclkPrevQ <= tclkS;
    end
  end

  assign tclkFall = tclkPrevQ & ~tclkS;

  // ---------------------------------------------------------------
  // per-channel transmit, receive and line configuration
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic       aQ;
    logic       bQ;
    logic       rpQ;
    logic       rnQ;
    logic       rcQ;
    logic       impQ;
    logic [3:0] lenQ;
    logic       useMon;

    assign useMon = (i == 0) && monOn;

    // loopback of the monitored signal outranks local transmit data
    always_ff @(posedge ref_clk) begin
      if (cfgClr) begin
        aQ    <= 1'b0;
        bQ    <= 1'b0;
      end else if (useMon && rlS) begin
        aQ <= monPos;  // [RQ8]
        bQ <= monNeg;
      end else if (allOnesS[i]) begin
        // toggle from the line itself: the first tick moves the line whatever data held it
        if (refTickQ) begin
          aQ <= ~aQ;  // [RQ4]
          bQ <= aQ;
        end
      end else if (tclkFall[i]) begin
        aQ <= tposS[i];  // [RQ20] [RQ14]
        bQ <= tnegS[i];
      end
    end

    // receive outputs; channel zero carries the monitored signal
    always_ff @(posedge ref_clk) begin
      if (cfgClr) begin
        rpQ <= 1'b0;
        rnQ <= 1'b0;
        rcQ <= 1'b0;
      end else if (useMon) begin
        rpQ <= monPos;  // [RQ8]
        rnQ <= monNeg;
        rcQ <= monClk;
      end else begin
        rpQ <= rxPosS[i];  // [RQ21]
        rnQ <= rxNegS[i];
        rcQ <= losS[i] ? refLvlQ : rxClkS[i];  // [RQ3]
      end
    end

    // strap pins serve all channels; host mode per channel, pin unused
    always_ff @(posedge ref_clk) begin
      if (cfgClr) begin
        lenQ <= RST_REACH;
        impQ <= 1'b0;
      end else if (hostModeS) begin
        lenQ <= reachQ[i];  // [RQ17] [RQ19]
        impQ <= reachQ[i][IMP_HOST_BIT];  // [RQ18]
      end else begin
        lenQ <= {1'b0, reachS};  // [RQ15] [RQ14]
        impQ <= (reachS == REACH_E1) & cblS;  // [RQ16]
      end
    end

    assign txAW[i]              = aQ;
    assign txBW[i]              = bQ;
    assign lineOutA[i]          = aQ;
    assign lineOutB[i]          = bQ;
    assign rxPositiveData[i]    = rpQ;
    assign rxNegativeData[i]    = rnQ;
    assign rxClockOut[i]        = rcQ;
    assign lineReach[i*4 +: 4]  = lenQ;
    assign lineImp75[i]         = impQ;
  end

  // ---------------------------------------------------------------
  // timing recovery selection
  // ---------------------------------------------------------------
  logic [7:0] trModeQ;

  // strap pin can only ever reach channel zero
  always_ff @(posedge ref_clk) begin
    if (cfgClr) begin
      trModeQ <= 8'h00;
    end else if (hostModeS) begin
      trModeQ <= trEnQ;  // [RQ13]
    end else begin
      trModeQ <= {7'h00, trPinS};  // [RQ12]
    end
  end

  assign timingRecovery = trModeQ;
  assign regRdata       = regRdataQ;
  assign hostWait       = hostWaitQ;
  assign powerReady     = readyQ;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_cal_done: assert property (@(posedge ref_clk) disable iff (srst) // [RQ1]
    pwrQ == PWR_CAL && calCntQ == CAL_LAST |=> readyQ)
    else $error("calibration did not end on count");
  chk_regs_default: assert property (@(posedge ref_clk) disable iff (srst) // [RQ1]
    !readyQ |=> monSelQ == RST_MON_SEL && trEnQ == RST_TR_ENABLE)
    else $error("registers not at default before ready");
  chk_los_clock: assert property (@(posedge ref_clk) disable iff (srst) // [RQ3]
    readyQ && losS[1] |=> rxClockOut[1] == $past(refLvlQ))
    else $error("los clock not from reference");
  chk_all_ones: assert property (@(posedge ref_clk) disable iff (srst) // [RQ4]
    readyQ && allOnesS[2] && refTickQ |=> $changed(lineOutA[2]) && (lineOutA[2] ^ lineOutB[2]))
    else $error("all-ones mark missing on tick");
  chk_wait_clear: assert property (@(posedge ref_clk) disable iff (srst) // [RQ5]
    hostWaitQ && refTickQ && !regWe && !regRe |=> !hostWaitQ)
    else $error("wait not cleared on reference tick");
  chk_mon_route: assert property (@(posedge ref_clk) disable iff (srst) // [RQ7]
    readyQ && monOn |=> rxPositiveData[0] == $past(monPos) && rxClockOut[0] == $past(monClk))
    else $error("monitored signal not on channel zero");
  chk_mon_loop: assert property (@(posedge ref_clk) disable iff (srst) // [RQ8]
    readyQ && monOn && rlS |=> lineOutA[0] == $past(monPos) && lineOutB[0] == $past(monNeg))
    else $error("loopback does not carry monitored signal");
  chk_strap_tr: assert property (@(posedge ref_clk) disable iff (srst) // [RQ12]
    readyQ && !hostModeS |=> timingRecovery[7:1] == 7'h00 && timingRecovery[0] == $past(trPinS))
    else $error("strap recovery reached a wrong channel");
  chk_host_tr: assert property (@(posedge ref_clk) disable iff (srst) // [RQ13]
    readyQ && hostModeS |=> timingRecovery == $past(trEnQ))
    else $error("host recovery enable not applied");
  chk_tx_sample: assert property (@(posedge ref_clk) disable iff (srst) // [RQ20]
    readyQ && tclkFall[3] && !allOnesS[3] |=> lineOutA[3] == $past(tposS[3]))
    else $error("transmit data not sampled on falling edge");
  chk_host_imp: assert property (@(posedge ref_clk) disable iff (srst) // [RQ18]
    readyQ && hostModeS |=> lineImp75[0] == $past(reachQ[0][IMP_HOST_BIT]))
    else $error("host impedance follows the pin");
  chk_mon_off: assert property (@(posedge ref_clk) disable iff (srst) // [RQ21]
    readyQ && !monOn && !losS[0] |=> rxPositiveData[0] == $past(rxPosS[0]))
    else $error("channel zero not ordinary when monitor off");

endmodule : ocl_channel_ctrl
`default_nettype wire

// >>> src/ocl_pkg.sv
// What this block does
// [RQ1] after supply trips, calibrate, clear control registers and machines, ready in 30 ms
// [RQ2] system feeds a 2.048 or 1.544 MHz reference within 100 ppm; here the tick is 20 MHz divided by 9, about 2.22 MHz
// [RQ3] a channel in loss of signal takes its recovered clock from the reference
// [RQ4] all-ones alarm output is timed by the reference, not the transmit clock
// [RQ5] host wait-state timing comes from the reference
// [RQ6] system feeds the reference from its own oscillator, not a jittery clock
// [RQ7] any channel one to seven, receive or transmit, can feed channel zero
// [RQ8] monitored signal appears on channel zero outputs, and on line during loopback
// [RQ9] host mode takes the monitor choice from register 0Bh
// [RQ10] strap codes: x000 off, 0001-0111 receivers, 1001-1111 transmitters
// [RQ11] system holds the fifth address pin low in strap mode
// [RQ12] strap mode: timing-recovery pin makes channel zero alone a clock recovery unit
// [RQ13] host mode: each bit of register 1Eh enables clock recovery on its channel
// [RQ14] transmitters take bipolar data and shape the pulse internally
// [RQ15] strap mode: three reach pins pick one pulse shape for all transmitters
// [RQ16] strap mode: impedance pin picks 120 or 75 ohm when reach code is E1
// [RQ17] host writes channel to 10h, then reach code to 11h for that channel
// [RQ18] host mode ignores the impedance select pin
// [RQ19] host mode sets each channel to T1/J1 or E1 on its own
// [RQ20] bipolar mode samples data at each falling transmit clock edge, no coding
// [RQ21] with monitoring off, channel zero works as an ordinary channel
package ocl_pkg;

  // ---------------------------------------------------------------
  // clocking and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned REF_HZ      = 2_048_000;
  localparam int unsigned REF_DIV     = CLK_HZ / REF_HZ;
  localparam int unsigned CAL_TIME_MS = 30;
  localparam int unsigned CAL_CYCLES  = (CLK_HZ / 1000) * CAL_TIME_MS;
  localparam int unsigned NCH         = 8;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MON_SEL   = 8'h0B;
  localparam logic [7:0] OFS_LL_INDEX  = 8'h10;
  localparam logic [7:0] OFS_LL_VALUE  = 8'h11;
  localparam logic [7:0] OFS_TR_ENABLE = 8'h1E;
  localparam logic [7:0] OFS_STATUS    = 8'h1F;

  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MON_SEL   = 8'h00;
  localparam logic [7:0] RST_LL_INDEX  = 8'h00;
  localparam logic [7:0] RST_TR_ENABLE = 8'h00;
  localparam logic [3:0] RST_REACH     = 4'h0;
  localparam int unsigned MON_TX_BIT   = 3;
  localparam int unsigned IMP_HOST_BIT = 3;
  localparam logic [2:0] REACH_E1      = 3'h0;

  typedef enum logic [1:0] {PWR_STATIC, PWR_CAL, PWR_RUN} ocl_pwr_e;

endpackage : ocl_pkg

// >>> src/ocl_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module ocl_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1Q;
  logic [W-1:0] s2Q;
  logic [W-1:0] s3Q;
  logic [W-1:0] levelQ;

  // three stages; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    s1Q <= din;
    s2Q <= s1Q;
    s3Q <= s2Q;
  end

  // a bit changes only once stages two and three agree
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (srst) begin
        levelQ[b] <= 1'b0;
      end else if (s2Q[b] == s3Q[b]) begin
        levelQ[b] <= s3Q[b];
      end
    end
  end

  assign dout = levelQ;

endmodule : ocl_sync3
`default_nettype wire

// >>> verif/ocl_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side framer: per-channel transmit clock and bipolar data
module ocl_framer_model (
  input  wire logic       run,
  input  wire logic       alt,
  input  wire logic [7:0] pattern,
  output logic      [7:0] transmit_clock_in,
  output logic      [7:0] tx_positive_data,
  output logic      [7:0] tx_negative_data,
  output logic      [7:0] sampled
);
  logic clk;

  // 400 ns clock, odd start offset keeps its edges off ref_clk edges at a fixed phase; still when idle
  initial begin
    clk = 1'b0;
    #7;
    forever begin
      #200;
      clk = run ? ~clk : 1'b0;
    end
  end

  assign transmit_clock_in = {8{clk}};

  // data launched on the rising edge so it is settled at the falling edge
  initial begin
    tx_positive_data = 8'h00;
    tx_negative_data = 8'hFF;
  end
  always @(posedge clk) begin
    tx_positive_data <= alt ? ~tx_positive_data : pattern;
    tx_negative_data <= alt ? tx_positive_data : ~pattern;
  end

  // what the line should carry: the value present at the falling edge
  always @(negedge clk) begin
    sampled <= tx_positive_data;
  end
endmodule : ocl_framer_model
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ocl_pkg::*;
  localparam int unsigned CAL_P = 20;  // short calibration for simulation
  logic        ref_clk = 1'b0;
  logic        srst, regWe, regRe, supplyOk, hostMode, remoteLoopback0, run, alt;
  logic        hostWait, powerReady, timingRecoveryPin, cableImpedanceSelect;
  logic [2:0]  cableReachCode;
  logic [3:0]  monitorSelectPins;
  logic [7:0]  regAddr, regWdata, regRdata, lossOfSignal, allOnesAlarm, rdv;
  logic [7:0]  lineRxPositive, lineRxNegative, lineRxClock, pattern;
  logic [7:0]  transmit_clock_in, tx_positive_data, tx_negative_data, sampled, lineOutA, lineOutB, lineImp75;
  logic [7:0]  rxPositiveData, rxNegativeData, rxClockOut, timingRecovery;
  logic [31:0] lineReach;
  int          errTotal, nChecks;

  // 20 MHz reference
  // own oscillator, never derived from the framer's transmit clock
  always #25 ref_clk = ~ref_clk;

  ocl_channel_ctrl #(.CAL_CYCLES_P(CAL_P)) dut_u (
    .ref_clk(ref_clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWe(regWe), .regRe(regRe), .regRdata(regRdata), .hostWait(hostWait),
    .powerReady(powerReady), .supplyOk(supplyOk), .hostMode(hostMode),
    .remoteLoopback0(remoteLoopback0), .timingRecoveryPin(timingRecoveryPin),
    .cableImpedanceSelect(cableImpedanceSelect), .cableReachCode(cableReachCode),
    .monitorSelectPins(monitorSelectPins), .transmitClockIn(transmit_clock_in),
    .txPositiveData(tx_positive_data), .txNegativeData(tx_negative_data), .lossOfSignal(lossOfSignal),
    .allOnesAlarm(allOnesAlarm), .lineRxPositive(lineRxPositive),
    .lineRxNegative(lineRxNegative), .lineRxClock(lineRxClock),
    .lineOutA(lineOutA), .lineOutB(lineOutB), .rxPositiveData(rxPositiveData),
    .rxNegativeData(rxNegativeData), .rxClockOut(rxClockOut),
    .lineReach(lineReach), .lineImp75(lineImp75), .timingRecovery(timingRecovery));

  ocl_framer_model framer_u (
    .run(run), .alt(alt), .pattern(pattern), .transmit_clock_in(transmit_clock_in), .tx_positive_data(tx_positive_data),
    .tx_negative_data(tx_negative_data), .sampled(sampled));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic waitN(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : waitN

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWe    <= 1'b1;
    @(posedge ref_clk);
    regWe    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRe   <= 1'b1;
    @(posedge ref_clk);
    regRe   <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  task automatic closeOut;
    $display("checks %0d errors %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : closeOut

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic tPower;
    int n;
    wr(OFS_TR_ENABLE, 8'hFF);  // dropped: device still static
    waitN(10);
    chk(powerReady, 0, "ready while static");
    @(posedge ref_clk);
    supplyOk <= 1'b1;
    n = 0;
    while (powerReady !== 1'b1 && n < CAL_P + 20) begin
      waitN(1);
      n++;
    end
    chk(n >= CAL_P && n <= CAL_P + 8, 1, "calibration length");
    rd(OFS_TR_ENABLE, rdv);
    chk(rdv, RST_TR_ENABLE, "recovery enable default");
    rd(OFS_MON_SEL, rdv);
    chk(rdv, RST_MON_SEL, "monitor select default");
  endtask : tPower

  task automatic tRegs;
    int n;
    wr(OFS_TR_ENABLE, 8'hA5);
    #1;
    chk(hostWait, 1, "wait after strobe");
    n = 0;
    while (hostWait !== 1'b0 && n < 30) begin
      waitN(1);
      n++;
    end
    chk(n >= 1 && n <= 2 * REF_DIV + 2, 1, "wait length");
    rd(OFS_TR_ENABLE, rdv);
    chk(rdv, 8'hA5, "recovery enable readback");
    waitN(2);
    chk(timingRecovery, 8'hA5, "recovery per channel");
    rd(8'h05, rdv);
    chk(rdv, 8'h00, "unmapped read");
  endtask : tRegs

  task automatic tReach;
    wr(OFS_LL_INDEX, 8'h02);
    wr(OFS_LL_VALUE, 8'h0D);
    wr(OFS_LL_INDEX, 8'h05);
    wr(OFS_LL_VALUE, 8'h03);
    @(posedge ref_clk);
    cableImpedanceSelect <= 1'b1;
    cableReachCode       <= 3'b000;
    waitN(8);
    chk(lineReach, 32'h0030_0D00, "host reach per channel");
    chk(lineImp75, 8'h04, "host impedance, pin ignored");
    wr(OFS_LL_INDEX, 8'h02);
    rd(OFS_LL_VALUE, rdv);
    chk(rdv, 8'h0D, "reach readback");
  endtask : tReach

  task automatic tStrap;
    @(posedge ref_clk);
    hostMode          <= 1'b0;
    timingRecoveryPin <= 1'b1;
    waitN(8);
    chk(lineImp75, 8'hFF, "E1 75 ohm all");
    chk(lineReach, 32'h0000_0000, "E1 reach all");
    chk(timingRecovery, 8'h01, "recovery on ch0 only");
    @(posedge ref_clk);
    cableReachCode <= 3'b011;
    waitN(8);
    chk(lineReach, 32'h3333_3333, "T1 reach all");
    chk(lineImp75, 8'h00, "T1 no 75 ohm");
    @(posedge ref_clk);
    cableReachCode       <= 3'b000;
    cableImpedanceSelect <= 1'b0;
    waitN(8);
    chk(lineImp75, 8'h00, "E1 120 ohm");
  endtask : tStrap

  // codes 0..8: receivers 1..7 and both disabled codes (ch0 own input)
  task automatic tMonRx;
    for (int k = 0; k < 9; k++) begin
      @(posedge ref_clk);
      monitorSelectPins <= k[3:0];
      lineRxPositive    <= 8'h01 << k[2:0];
      waitN(7);
      chk(rxPositiveData[0], 1, "monitor high");
      @(posedge ref_clk);
      lineRxPositive <= ~(8'h01 << k[2:0]);
      waitN(7);
      chk(rxPositiveData[0], 0, "monitor low");
    end
  endtask : tMonRx

  task automatic tMonHost;
    @(posedge ref_clk);
    hostMode       <= 1'b1;
    lineRxPositive <= 8'h40;
    wr(OFS_MON_SEL, 8'h06);
    waitN(7);
    chk(rxPositiveData[0], 1, "host monitor rx6");
    @(posedge ref_clk);
    remoteLoopback0 <= 1'b1;
    lineRxPositive  <= 8'hBF;
    waitN(8);
    chk(rxPositiveData[0], 0, "host monitor rx6 low");
    chk(lineOutA[0], 0, "loopback line low");
    @(posedge ref_clk);
    lineRxPositive <= 8'h40;
    waitN(8);
    chk(lineOutA[0], 1, "loopback line high");
    @(posedge ref_clk);
    remoteLoopback0 <= 1'b0;
    wr(OFS_MON_SEL, 8'h00);
  endtask : tMonHost

  // strap code 1011 watches transmitter 3
  task automatic tTx;
    @(posedge ref_clk);
    hostMode          <= 1'b0;
    monitorSelectPins <= 4'hB;  // no fifth pin: held low
    run               <= 1'b1;
    alt               <= 1'b1;
    repeat (6) begin
      @(negedge transmit_clock_in[3]);
      waitN(7);
      chk(lineOutA[3], sampled[3], "falling edge sample");
      chk(rxPositiveData[0], sampled[3], "tx3 monitor");
      chk(lineOutB[3], !sampled[3], "falling edge negative");
      chk(rxNegativeData[0], !sampled[3], "tx3 monitor neg");
    end
    @(posedge ref_clk);
    run <= 1'b0;
  endtask : tTx

  // transmit clock stopped: both paths must run from the reference alone
  task automatic tRefTiming;
    int na, nc;
    logic pa, pc;
    @(posedge ref_clk);
    allOnesAlarm <= 8'h04;
    lossOfSignal <= 8'h02;
    waitN(12);
    na = 0;
    nc = 0;
    pa = lineOutA[2];
    pc = rxClockOut[1];
    repeat (10 * REF_DIV) begin
      waitN(1);
      if (lineOutA[2] !== pa) na++;
      if (rxClockOut[1] !== pc) nc++;
      pa = lineOutA[2];
      pc = rxClockOut[1];
    end
    chk(na, 10, "all-ones timing");
    chk(nc, 10, "LOS recovered clock");
    @(posedge ref_clk);
    allOnesAlarm <= 8'h00;
    lossOfSignal <= 8'h00;
  endtask : tRefTiming

  // time-zero values, reset for 12 cycles, then the scenarios
  initial begin
    errTotal = 0;
    nChecks = 0;
    srst = 1'b1;
    {regWe, regRe, supplyOk, remoteLoopback0, run, alt} = '0;
    {timingRecoveryPin, cableImpedanceSelect, cableReachCode} = '0;
    hostMode = 1'b1;
    monitorSelectPins = 4'h0;
    {regAddr, regWdata, lossOfSignal, allOnesAlarm} = '0;
    {lineRxPositive, lineRxNegative, lineRxClock, pattern} = '0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    tPower();
    tRegs();
    tReach();
    tStrap();
    tMonRx();
    tMonHost();
    tTx();
    tRefTiming();
    closeOut();
  end

  // watchdog well beyond the expected few hundred cycles
  initial begin
    #2_000_000;
    errTotal++;
    closeOut();
  end
endmodule : tb_top
`default_nettype wire
